// File: include/ckpd_regs.svh
// register offsets, field positions, reset values and timing counts of the clock controller
// assumes a 32-bit ahb-lite slave with one aligned word per register
`ifndef CKPD_REGS_SVH
`define CKPD_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define CKPD_OFS_PWRCTL   6'h00
`define CKPD_OFS_AHB_CLOCK_ENABLE   6'h04
`define CKPD_OFS_APB_CLOCK_ENABLE   6'h08
`define CKPD_OFS_STATUS   6'h0c
`define CKPD_OFS_SEL0     6'h10
`define CKPD_OFS_SEL1     6'h14
`define CKPD_OFS_CLOCK_DIVIDER_NUMBER   6'h18
`define CKPD_OFS_SEL2     6'h1c
`define CKPD_OFS_PLLCTL   6'h20
`define CKPD_OFS_FREQUENCY_DIVIDER_CONTROL   6'h24

// ----------------------------------------------------------------
// power_down_control fields
// ----------------------------------------------------------------
`define CKPD_HXT_EN_BIT   0
`define CKPD_LXT_EN_BIT   1
`define CKPD_HIRC_EN_BIT  2
`define CKPD_LIRC_EN_BIT  3
`define CKPD_WK_DLY_BIT   4
`define CKPD_WK_IE_BIT    5
`define CKPD_WK_FLAG_BIT  6
`define CKPD_PD_EN_BIT    7
`define CKPD_WAIT_CPU_BIT 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CKPD_RST_PWRCTL   9'h01c
`define CKPD_RST_AHB_CLOCK_ENABLE   32'h0000000d
`define CKPD_RST_APB_CLOCK_ENABLE   32'h00000000
`define CKPD_RST_SEL0     6'h3f
`define CKPD_RST_SEL1     32'hffffffff
`define CKPD_RST_CLOCK_DIVIDER_NUMBER   32'h00000000
`define CKPD_RST_SEL2     32'h000000ff
`define CKPD_RST_PLLCTL   32'h0005c22e
`define CKPD_RST_FREQUENCY_DIVIDER_CONTROL   5'h00

// ----------------------------------------------------------------
// wake-up delay counts, in system clock cycles
// ----------------------------------------------------------------
`define CKPD_DLY_HXT_CYC  4096
`define CKPD_DLY_HIRC_CYC 256

`endif

// File: include/ckpd_pkg.sv
// types shared by the clock and power-down controller
// assumes nothing beyond a systemverilog compiler
package ckpd_pkg;

    // power sequencing states, one-hot
    typedef enum logic [2:0] {
        PD_ACTIVE = 3'b001,
        PD_DOWN   = 3'b010,
        PD_WKDLY  = 3'b100
    } ckpd_state_t;

    // clock source codes of the select fields
    typedef enum logic [2:0] {
        SRC_HXT  = 3'h0,
        SRC_LXT  = 3'h1,
        SRC_PLL  = 3'h2,
        SRC_LIRC = 3'h3,
        SRC_HIRC = 3'h7
    } ckpd_src_t;

endpackage

// File: design/ckpd_clock_ctrl.sv
// clock source selection, power-down sequencing and clock-out divider
// assumes source clocks arrive as levels synchronous to sys_clk, and an ahb-lite master
// Operation
// - five sources; pll fed from hxt or hirc
// - system clock follows select0 bits 2:0
// - systick uses cpu clock or select0 5:3
// - no cpu wait: enter power-down at once
// - cpu wait: enter power-down after cpu sleeps
// - stay powered down until wake-up event
// - power-down stops hxt and hirc
// - lxt and lirc follow only their enables
// - power-down stops pll and system clock
// - only low-speed peripheral clocks keep running
// - wake-up clears power-down enable bit
// - sixteen divide-by-two stages, one tapped out
// - divider output is input over 2^(n+1)
// - divider enable starts the chained counter
// - disabled divider stops only once output low
// - wake-up sets flag; write one clears
// - wake irq is flag and enable together
// - optional wake delay 4096 hxt, 256 hirc
// - four bits enable the four oscillators
//
// The AHB-Lite slave port was chosen for this implementation.
`include "ckpd_regs.svh"

module ckpd_clock_ctrl
    import ckpd_pkg::*;
#(
    parameter int NUM_PERIPH   = 8,
    parameter int WAKE_DLY_HXT = `CKPD_DLY_HXT_CYC
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // clock sources, sampled as levels
    input  wire logic                  hxtClk,
    input  wire logic                  lxtClk,
    input  wire logic                  pllClk,
    input  wire logic                  lircClk,
    input  wire logic                  hircClk,
    // core and system side
    input  wire logic                  cpuSleeping,
    input  wire logic                  wakeupEvent,
    input  wire logic                  writeProtectUnlock,
    input  wire logic                  systickCtrlClkSrc,
    input  wire logic [NUM_PERIPH-1:0] periphLowSpeedSrc,
    // oscillator and pll enables
    output logic                       hxtOscEn,
    output logic                       lxtOscEn,
    output logic                       hircOscEn,
    output logic                       lircOscEn,
    output logic                       pllEnable,
    output logic                       pllSrcHirc,
    // generated clocks and status
    output logic                       sysClkOut,
    output logic                       systickRefClock,
    output logic                       systickClock,
    output logic [NUM_PERIPH-1:0]      periphClkRun,
    output logic                       clockOutPin,
    output logic                       powerDown,
    output logic                       wakeupIrq
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [8:0]  pwrCtl_reg, pwrCtl_next;
    logic [31:0] ahb_clock_enable_reg, apb_clock_enable_reg, sel1_reg, clock_divider_number_reg, sel2_reg, pllCtl_reg;
    logic [5:0]  sel0_reg;
    logic [4:0]  frequency_divider_control_reg;
    logic [5:0]  addr_reg;
    logic        wrPend_reg, rdPend_reg;
    logic [31:0] rdData_reg;
    ckpd_state_t state_reg, state_next;
    logic [12:0] dlyCnt_reg;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire        busTake   = hsel && htrans[1] && hready;
    wire        wrPhase   = wrPend_reg;
    wire        wrPwr     = wrPhase && (addr_reg == `CKPD_OFS_PWRCTL);
    wire        wrSel0    = wrPhase && (addr_reg == `CKPD_OFS_SEL0);
    wire        wrFrq     = wrPhase && (addr_reg == `CKPD_OFS_FREQUENCY_DIVIDER_CONTROL);
    wire [5:0]  rdAddr    = addr_reg;
    wire        inPd      = (state_reg == PD_DOWN);
    wire        clocksOff = (state_reg != PD_ACTIVE);
    wire [31:0] statusWord = {26'h0, clocksOff, pllEnable, lircOscEn, hircOscEn,
                              lxtOscEn, hxtOscEn};
    logic [31:0] rdMux;

    always_comb begin
        case (rdAddr)
            `CKPD_OFS_PWRCTL: rdMux = {23'h0, pwrCtl_reg};
            `CKPD_OFS_AHB_CLOCK_ENABLE: rdMux = ahb_clock_enable_reg;
            `CKPD_OFS_APB_CLOCK_ENABLE: rdMux = apb_clock_enable_reg;
            `CKPD_OFS_STATUS: rdMux = statusWord;
            `CKPD_OFS_SEL0:   rdMux = {26'h0, sel0_reg};
            `CKPD_OFS_SEL1:   rdMux = sel1_reg;
            `CKPD_OFS_CLOCK_DIVIDER_NUMBER: rdMux = clock_divider_number_reg;
            `CKPD_OFS_SEL2:   rdMux = sel2_reg;
            `CKPD_OFS_PLLCTL: rdMux = pllCtl_reg;
            `CKPD_OFS_FREQUENCY_DIVIDER_CONTROL: rdMux = {27'h0, frequency_divider_control_reg};
            default:          rdMux = 32'h0;
        endcase
    end

    // reads take one wait state so a write just before is already visible
    assign hreadyout = !rdPend_reg;
    assign hresp     = 1'b0;
    assign hrdata    = rdData_reg;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg   <= 6'h00;
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            rdData_reg <= 32'h0;
        end else begin
            wrPend_reg <= busTake && hwrite;
            rdPend_reg <= busTake && !hwrite;
            if (busTake) begin
                addr_reg <= {haddr[5:2], 2'b00};
            end
            if (rdPend_reg) begin
                rdData_reg <= rdMux;
            end
        end
    end

    // ----------------------------------------------------------------
    // power-down control register
    // ----------------------------------------------------------------
    wire wakeNow   = inPd && wakeupEvent;
    wire flagClear = wrPwr && hwdata[`CKPD_WK_FLAG_BIT];
    wire lockedWr  = wrPwr && writeProtectUnlock;

    always_comb begin
        pwrCtl_next = pwrCtl_reg;
        if (lockedWr) begin
            pwrCtl_next[8:7] = hwdata[8:7];
            pwrCtl_next[5:0] = hwdata[5:0];
        end
        if (flagClear) begin
            pwrCtl_next[`CKPD_WK_FLAG_BIT] = 1'b0;
        end
        if (wakeNow) begin
            pwrCtl_next[`CKPD_WK_FLAG_BIT] = 1'b1;
            pwrCtl_next[`CKPD_PD_EN_BIT]   = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwrCtl_reg <= `CKPD_RST_PWRCTL;
            ahb_clock_enable_reg <= `CKPD_RST_AHB_CLOCK_ENABLE;
            apb_clock_enable_reg <= `CKPD_RST_APB_CLOCK_ENABLE;
            sel0_reg   <= `CKPD_RST_SEL0;
            sel1_reg   <= `CKPD_RST_SEL1;
            clock_divider_number_reg <= `CKPD_RST_CLOCK_DIVIDER_NUMBER;
            sel2_reg   <= `CKPD_RST_SEL2;
            pllCtl_reg <= `CKPD_RST_PLLCTL;
            frequency_divider_control_reg <= `CKPD_RST_FREQUENCY_DIVIDER_CONTROL;
        end else begin
            pwrCtl_reg <= pwrCtl_next;
            if (wrPhase && addr_reg == `CKPD_OFS_AHB_CLOCK_ENABLE) ahb_clock_enable_reg <= hwdata;
            if (wrPhase && addr_reg == `CKPD_OFS_APB_CLOCK_ENABLE) apb_clock_enable_reg <= hwdata;
            if (wrSel0) sel0_reg <= hwdata[5:0];
            if (wrPhase && addr_reg == `CKPD_OFS_SEL1) sel1_reg <= hwdata;
            if (wrPhase && addr_reg == `CKPD_OFS_CLOCK_DIVIDER_NUMBER) clock_divider_number_reg <= hwdata;
            if (wrPhase && addr_reg == `CKPD_OFS_SEL2) sel2_reg <= hwdata;
            if (wrPhase && addr_reg == `CKPD_OFS_PLLCTL) pllCtl_reg <= hwdata;
            if (wrFrq) frequency_divider_control_reg <= hwdata[4:0];
        end
    end

    wire pdEnable   = pwrCtl_reg[`CKPD_PD_EN_BIT];
    wire waitCpu    = pwrCtl_reg[`CKPD_WAIT_CPU_BIT];
    wire wakeFlag   = pwrCtl_reg[`CKPD_WK_FLAG_BIT];
    wire wakeIrqEn  = pwrCtl_reg[`CKPD_WK_IE_BIT];
    wire wakeDlyEn  = pwrCtl_reg[`CKPD_WK_DLY_BIT];
    wire [2:0] sysSel = sel0_reg[2:0];
    wire [2:0] stSel  = sel0_reg[5:3];

    assign wakeupIrq = wakeFlag && wakeIrqEn;

    // ----------------------------------------------------------------
    // power-down sequencer
    // ----------------------------------------------------------------
    wire        enterPd  = pdEnable && (!waitCpu || cpuSleeping);
    wire        dlyOnHxt = (sysSel == SRC_HXT);
    wire        dlyOnIrc = (sysSel == SRC_HIRC);
    wire        useDly   = wakeDlyEn && (dlyOnHxt || dlyOnIrc);
    wire [12:0] dlyLoad  = dlyOnHxt ? 13'(WAKE_DLY_HXT - 1) : 13'(`CKPD_DLY_HIRC_CYC - 1);

    always_comb begin
        case (state_reg)
            PD_ACTIVE: state_next = enterPd ? PD_DOWN : PD_ACTIVE;
            PD_DOWN: begin
                if (wakeupEvent) begin
                    state_next = useDly ? PD_WKDLY : PD_ACTIVE;
                end else begin
                    state_next = PD_DOWN;
                end
            end
            PD_WKDLY: state_next = (dlyCnt_reg == 13'h0) ? PD_ACTIVE : PD_WKDLY;
            default:  state_next = PD_ACTIVE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= PD_ACTIVE;
            dlyCnt_reg <= 13'h0;
        end else begin
            state_reg <= state_next;
            if (wakeNow) begin
                dlyCnt_reg <= dlyLoad;
            end else if (dlyCnt_reg != 13'h0) begin
                dlyCnt_reg <= dlyCnt_reg - 13'h1;
            end
        end
    end

    assign powerDown  = inPd;
    // high-speed sources stop, low-speed ones only follow their enable bits
    assign hxtOscEn   = pwrCtl_reg[`CKPD_HXT_EN_BIT] && !inPd;
    assign hircOscEn  = pwrCtl_reg[`CKPD_HIRC_EN_BIT] && !inPd;
    assign lxtOscEn   = pwrCtl_reg[`CKPD_LXT_EN_BIT];
    assign lircOscEn  = pwrCtl_reg[`CKPD_LIRC_EN_BIT];
    assign pllEnable  = !inPd;
    assign pllSrcHirc = pllCtl_reg[19];

    genvar p;
    generate
        for (p = 0; p < NUM_PERIPH; p++) begin : g_periph
            assign periphClkRun[p] = !inPd || periphLowSpeedSrc[p];
        end
    endgenerate

    // ----------------------------------------------------------------
    // glitch-free source multiplexers
    // ----------------------------------------------------------------
    wire [4:0] srcLevels = {hircClk, lircClk, pllClk, lxtClk, hxtClk};

    function automatic logic pickSrc(input logic [4:0] lv, input logic [2:0] code);
        case (code)
            SRC_HXT:  pickSrc = lv[0];
            SRC_LXT:  pickSrc = lv[1];
            SRC_PLL:  pickSrc = lv[2];
            SRC_LIRC: pickSrc = lv[3];
            default:  pickSrc = lv[4];
        endcase
    endfunction

    // switch only while both old and new source sit low, so no pulse is cut
    logic [2:0] sysAct_reg, stAct_reg;
    logic       sysClk_reg, stRef_reg, systick_ref_clock_reg;
    wire        sysNew = pickSrc(srcLevels, sysSel);
    wire        sysCur = pickSrc(srcLevels, sysAct_reg);
    wire        stNew  = pickSrc(srcLevels, stSel);
    wire        stCur  = pickSrc(srcLevels, stAct_reg);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sysAct_reg <= SRC_HIRC;
            stAct_reg  <= SRC_HIRC;
            sysClk_reg <= 1'b0;
            stRef_reg  <= 1'b0;
            systick_ref_clock_reg  <= 1'b0;
        end else begin
            if (!sysClk_reg && !sysNew) sysAct_reg <= sysSel;
            if (!stRef_reg && !stNew) stAct_reg <= stSel;
            sysClk_reg <= sysCur && !clocksOff;
            stRef_reg  <= stCur;
            systick_ref_clock_reg  <= systickCtrlClkSrc ? sysClk_reg : stRef_reg;
        end
    end

    assign sysClkOut       = sysClk_reg;
    assign systickRefClock = stRef_reg;
    assign systickClock    = systick_ref_clock_reg;

    // ----------------------------------------------------------------
    // frequency divider
    // ----------------------------------------------------------------
    logic [15:0] divCnt_reg;
    logic        divRun_reg, divOut_reg, divInPrev_reg;
    wire  [3:0]  divTap  = frequency_divider_control_reg[3:0];
    wire         divEn   = frequency_divider_control_reg[4];
    wire         divTick = sysClk_reg && !divInPrev_reg;
    wire         tapLvl  = divCnt_reg[divTap];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_reg    <= 16'h0;
            divRun_reg    <= 1'b0;
            divOut_reg    <= 1'b0;
            divInPrev_reg <= 1'b0;
        end else begin
            divInPrev_reg <= sysClk_reg;
            if (divEn) begin
                divRun_reg <= 1'b1;
            end else if (!tapLvl) begin
                divRun_reg <= 1'b0;
            end
            if (divRun_reg && divTick) begin
                divCnt_reg <= divCnt_reg + 16'h1;
            end
            divOut_reg <= divRun_reg && tapLvl;
        end
    end

    assign clockOutPin = divOut_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_wake_with_dly;
        (state_reg == PD_DOWN) && wakeupEvent && wakeDlyEn && dlyOnIrc;
    endsequence
    sequence s_hold_dly;
        (state_reg == PD_WKDLY) [*8];
    endsequence

    a_pd_immediate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_reg == PD_ACTIVE) && pdEnable && !waitCpu |=> (state_reg == PD_DOWN))
        else $error("power-down not entered at once");
    a_wait_for_cpu_sleep: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_reg == PD_ACTIVE) && waitCpu && !cpuSleeping |=> (state_reg != PD_DOWN))
        else $error("power-down entered without cpu sleep");
    a_pd_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        inPd && !wakeupEvent |=> inPd)
        else $error("power-down left without wake-up");
    a_hs_osc_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        inPd |-> !hxtOscEn && !hircOscEn)
        else $error("high-speed source running in power-down");
    a_ls_osc_kept: assert property (@(posedge sys_clk) disable iff (!reset_n)
        inPd && $past(inPd) |-> lircOscEn == pwrCtl_reg[`CKPD_LIRC_EN_BIT])
        else $error("low-speed source disturbed by power-down");
    a_sysclk_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        inPd ##1 inPd |-> !sysClkOut && !pllEnable)
        else $error("system clock running in power-down");
    a_periph_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        inPd |-> periphClkRun == periphLowSpeedSrc)
        else $error("peripheral clock gating wrong");
    a_wake_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wakeNow |=> !pdEnable && wakeFlag)
        else $error("wake-up did not clear enable or set flag");
    a_wake_irq: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wakeNow && wakeIrqEn |=> wakeupIrq)
        else $error("wake-up interrupt missing");
    a_wake_delay: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_wake_with_dly |=> s_hold_dly ##249 (state_reg == PD_ACTIVE))
        else $error("wake-up delay wrong");
    a_div_stop: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !divEn && !divRun_reg |=> !clockOutPin)
        else $error("divider output not held low");

endmodule

// File: bench/ckpd_far_side.sv
// far-side model: source clocks, cpu sleep handshake, wake source and unlock key check
// assumes its requests change right after a rising sys_clk edge
module ckpd_far_side (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // enables from the controller
    input  wire logic       hxtOscEn,
    input  wire logic       lxtOscEn,
    input  wire logic       hircOscEn,
    input  wire logic       lircOscEn,
    input  wire logic       pllEnable,
    // bench requests
    input  wire logic       sleepReq,
    input  wire logic       wakeReq,
    input  wire logic       keyValid,
    input  wire logic [7:0] keyByte,
    // towards the controller
    output logic            hxtClk,
    output logic            lxtClk,
    output logic            pllClk,
    output logic            lircClk,
    output logic            hircClk,
    output logic            cpuSleeping,
    output logic            wakeupEvent,
    output logic            writeProtectUnlock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] divCnt;
    logic [1:0] keyStep;
    // ----------------------------------------------------------------
    // sources
    // ----------------------------------------------------------------
    // a stopped oscillator rests low, so a gating slip shows as a dead clock
    assign hxtClk             = divCnt[1] & hxtOscEn;
    assign pllClk             = divCnt[0] & pllEnable;
    assign hircClk            = divCnt[2] & hircOscEn;
    assign lxtClk             = divCnt[3] & lxtOscEn;
    assign lircClk            = divCnt[4] & lircOscEn;
    assign writeProtectUnlock = (keyStep == 2'h3);
    // ----------------------------------------------------------------
    // core handshake and unlock keys
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt      <= 5'h00;
            keyStep     <= 2'h0;
            cpuSleeping <= 1'b0;
            wakeupEvent <= 1'b0;
        end else begin
            divCnt      <= divCnt + 5'h01;
            cpuSleeping <= sleepReq & !wakeReq;
            wakeupEvent <= wakeReq;
            // keys count only in order; any other byte locks again
            if (keyValid) begin
                keyStep <= (keyStep == 2'h0 && keyByte == 8'h59) ? 2'h1 :
                           (keyStep == 2'h1 && keyByte == 8'h16) ? 2'h2 :
                           (keyStep == 2'h2 && keyByte == 8'h88) ? 2'h3 : 2'h0;
            end
        end
    end
endmodule

// File: bench/clock_power_down_controller_test.sv
// self-checking bench of the clock and power-down controller
// assumes the far-side model ckpd_far_side and a single ahb-lite slave
module clock_power_down_controller_test import ckpd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        systickCtrlClkSrc = 1'b0, sleepReq = 1'b0, wakeReq = 1'b0, keyValid = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  keyByte = 8'h00, periphLowSpeedSrc = 8'ha5;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    wire  [31:0] hrdata;
    wire  [7:0]  periphClkRun;
    wire         hready, hxtClk, lxtClk, pllClk, lircClk, hircClk;
    wire         cpuSleeping, wakeupEvent, writeProtectUnlock, hxtOscEn, lxtOscEn;
    wire         hircOscEn, lircOscEn, pllEnable, sysClkOut, systickRefClock, systickClock;
    wire         clockOutPin, powerDown, wakeupIrq, pllSrcHirc, hresp;
    int          failures = 0, checked = 0, cs, ct, ck, co, n;
    ckpd_src_t   srcs [5] = '{SRC_HXT, SRC_LXT, SRC_PLL, SRC_LIRC, SRC_HIRC};
    int          edges[5] = '{32, 8, 64, 4, 16};
    logic [31:0] rstVal[11] = '{32'h1c, 32'hd, 32'h0, 32'h1c, 32'h3f, 32'hffffffff,
                                32'h0, 32'hff, 32'h5c22e, 32'h0, 32'h0};
    logic [7:0]  keys[3] = '{8'h59, 8'h16, 8'h88};
    always #50 sys_clk = ~sys_clk;
    ckpd_clock_ctrl #(.NUM_PERIPH(8), .WAKE_DLY_HXT(16)) dut_u (
        .sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hrdata, .hreadyout(hready), .hresp, .hxtClk, .lxtClk, .pllClk, .lircClk, .hircClk,
        .cpuSleeping, .wakeupEvent, .writeProtectUnlock, .systickCtrlClkSrc,
        .periphLowSpeedSrc, .hxtOscEn, .lxtOscEn, .hircOscEn, .lircOscEn, .pllEnable,
        .pllSrcHirc, .sysClkOut, .systickRefClock, .systickClock, .periphClkRun,
        .clockOutPin, .powerDown, .wakeupIrq);
    ckpd_far_side far_u (.sys_clk, .reset_n, .hxtOscEn, .lxtOscEn, .hircOscEn, .lircOscEn,
        .pllEnable, .sleepReq, .wakeReq, .keyValid, .keyByte, .hxtClk, .lxtClk, .pllClk,
        .lircClk, .hircClk, .cpuSleeping, .wakeupEvent, .writeProtectUnlock);
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic expect_in(input logic [31:0] got, input logic [31:0] lo,
                             input logic [31:0] hi);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // waits sample the value settled before each edge
    task automatic wait_ready();
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            failures++;
            give_verdict();
        end
    endtask
    task automatic wait_pd(input logic lvl, input int lim);
        n = 0;
        while (powerDown !== lvl && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        if (powerDown !== lvl) begin
            failures++;
            give_verdict();
        end
    endtask
    // entered right after a rising edge; read data taken at the closing edge
    task automatic xfer(input logic wr, input logic [5:0] ofs, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {26'h0, ofs};
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic rdc(input logic [5:0] ofs, input logic [31:0] exp);
        xfer(1'b0, ofs, 32'h0);
        expect_in(rd, exp, exp);
    endtask
    task automatic measure();
        logic ps, pt, pk, po;
        {cs, ct, ck, co} = '0;
        {ps, pt, pk, po} = {sysClkOut, systickRefClock, systickClock, clockOutPin};
        repeat (128) begin
            @(posedge sys_clk);
            cs += int'(sysClkOut & !ps);
            ct += int'(systickRefClock & !pt);
            ck += int'(systickClock & !pk);
            co += int'(clockOutPin & !po);
            {ps, pt, pk, po} = {sysClkOut, systickRefClock, systickClock, clockOutPin};
        end
    endtask
    task automatic wake();
        wakeReq  <= 1'b1;
        sleepReq <= 1'b0;
        @(posedge sys_clk);
        wakeReq  <= 1'b0;
        wait_pd(1'b0, 10);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(8);
        reset_n <= 1'b1;
        tick(1);
        for (int i = 0; i < 11; i++) begin
            rdc(6'(4 * i), rstVal[i]);
        end
        expect_in({hresp, pllSrcHirc}, 0, 0);
        xfer(1'b1, 6'h20, 32'h00080000);
        tick(1);
        expect_in({hresp, pllSrcHirc}, 1, 1);
        xfer(1'b1, 6'h00, 32'h0cf);
        rdc(6'h00, 32'h01c);
        foreach (keys[i]) begin
            keyValid <= 1'b1;
            keyByte  <= keys[i];
            @(posedge sys_clk);
        end
        keyValid <= 1'b0;
        xfer(1'b1, 6'h00, 32'h00f);
        rdc(6'h0c, 32'h01f);
        for (int i = 0; i < 5; i++) begin
            systickCtrlClkSrc <= i[0];
            xfer(1'b1, 6'h10, {26'h0, srcs[(i + 1) % 5], srcs[i]});
            tick(40);
            measure();
            expect_in(cs, edges[i] - 1, edges[i] + 1);
            expect_in(ct, edges[(i + 1) % 5] - 1, edges[(i + 1) % 5] + 1);
            expect_in(ck, edges[(i + 1 - i[0]) % 5] - 1, edges[(i + 1 - i[0]) % 5] + 1);
            expect_in(co, 0, 0);
        end
        xfer(1'b1, 6'h10, 32'h03a);
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, 6'h24, 32'h10 | k);
            tick(40);
            measure();
            expect_in(co, (64 >> (k + 1)) - 1, (64 >> (k + 1)) + 1);
        end
        xfer(1'b1, 6'h24, 32'h003);
        tick(40);
        measure();
        expect_in(co + clockOutPin, 0, 0);
        xfer(1'b1, 6'h00, 32'h08f);
        wait_pd(1'b1, 4);
        tick(30);
        expect_in({powerDown, hxtOscEn, hircOscEn, pllEnable, lxtOscEn, lircOscEn},
                  6'h23, 6'h23);
        expect_in(periphClkRun, 8'ha5, 8'ha5);
        measure();
        expect_in(cs, 0, 0);
        wake();
        rdc(6'h00, 32'h04f);
        expect_in(wakeupIrq, 0, 0);
        xfer(1'b1, 6'h00, 32'h04f);
        rdc(6'h00, 32'h00f);
        xfer(1'b1, 6'h00, 32'h1af);
        tick(20);
        expect_in(powerDown, 0, 0);
        sleepReq <= 1'b1;
        wait_pd(1'b1, 6);
        wake();
        expect_in(wakeupIrq, 1, 1);
        rdc(6'h00, 32'h16f);
        xfer(1'b1, 6'h00, 32'h16f);
        tick(1);
        expect_in(wakeupIrq, 0, 0);
        // hirc first, then hxt with its shortened count
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, 6'h10, i ? 32'h038 : 32'h03f);
            xfer(1'b1, 6'h00, 32'h09f);
            wait_pd(1'b1, 6);
            wake();
            n = 0;
            while (sysClkOut !== 1'b1 && n < 400) begin
                @(posedge sys_clk);
                n++;
            end
            expect_in(n, (i ? 16 : 256) - 2, (i ? 16 : 256) + 12);
        end
        give_verdict();
    end
endmodule
